//--- hw/tmr2_map.svh
`ifndef TMR2_MAP_SVH
`define TMR2_MAP_SVH
// Register word addresses (Avalon word index)
`define TMR2_ADDR_CTRL      3'h0
`define TMR2_ADDR_MODE      3'h1
`define TMR2_ADDR_CNT_LO    3'h2
`define TMR2_ADDR_CNT_HI    3'h3
`define TMR2_ADDR_RLD_LO    3'h4
`define TMR2_ADDR_RLD_HI    3'h5
// Control register bit positions
`define TMR2_CTRL_OVF       7
`define TMR2_CTRL_EXT       6
`define TMR2_CTRL_RXB       5
`define TMR2_CTRL_TXB       4
`define TMR2_CTRL_EXEN      3
`define TMR2_CTRL_RUN       2
`define TMR2_CTRL_CT        1
`define TMR2_CTRL_CPRL      0
// Mode register bit positions
`define TMR2_MODE_OE        1
`define TMR2_MODE_DOWN_COUNT_ENABLE      0
// Reset values
`define TMR2_CTRL_RST       8'h00
`define TMR2_MODE_RST       2'h0
`define TMR2_CNT_RST        16'h0000
`define TMR2_ALL_ONES       16'hFFFF
// Machine cycle: oscillator clocks per timer tick
`define TMR2_MCYC_DIV       3'h6
`define TMR2_MCYC_LAST      3'h5
// Baud tick = rollover rate / 16
`define TMR2_BAUD_DIV_LAST  4'hF
`endif

//--- hw/tmr2_pkg.sv
package tmr2_pkg;
  // Operating mode, one-hot
  typedef enum logic [4:0] {
    TMR2_OFF     = 5'b00001,
    TMR2_CAPTURE = 5'b00010,
    TMR2_RELOAD  = 5'b00100,
    TMR2_CLKOUT  = 5'b01000,
    TMR2_BAUD    = 5'b10000
  } tmr2_mode_type;
  // Pin-side signals
  typedef struct packed {
    logic count_pin;
    logic trigger_pin;
  } tmr2_pins_type;
  // Baud ticks sent to the UART
  typedef struct packed {
    logic tx_tick;
    logic rx_tick;
  } tmr2_baud_type;
endpackage

//--- hw/tmr2_core.sv
// Contract
// - Capture mode without external enable: plain 16-bit timer, overflow sets overflow flag.
// - Capture mode with external enable: trigger falling edge copies count into reload registers.
// - Trigger edge sets external flag; both flags drive one interrupt.
// - Capture never reloads the count; counting continues through captures.
// - Captured values unprotected; each new trigger edge overwrites them.
// - Down-count enable selects direction behaviour; clear after reset, so count up.
// - Counting up without external enable: overflow at FFFF sets flag and reloads.
// - Counting up with external enable: overflow or trigger edge reloads; edge sets flag.
// - Trigger edge detection: sampled high, then low, flag set one cycle later.
// - Down-count enabled, trigger high: count up, overflow sets flag, reload.
// - Down-count enabled, trigger low: count down, underflow at reload value loads FFFF.
// - Up/down mode: external flag toggles on each overflow and underflow.
// - Clock-out frequency is osc over twice (65536 minus reload); reload on rollover.
// - Clock-out rollovers raise no interrupt.
// - Tx and rx baud select independently choose this timer as UART baud source.
// - Baud mode: each high-byte rollover reloads the 16-bit count.
// - Baud mode internal clocking counts at oscillator rate; baud is rollover rate over 16.
// - Baud mode rollover sets no overflow flag and no interrupt.
// - Baud mode with external enable: trigger edge sets external flag, no reload.
// - Timer counts only while run bit is set.
// - Either baud select set forces auto-reload, ignoring capture/reload select.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_map.svh"

module tmr2_core
  import tmr2_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins: count pin is two-way
  input  wire logic        count_pin_in,
  output logic             count_pin_out,
  output logic             count_pin_oe,
  input  wire logic        trigger_pin_in,
  // Interrupt request and UART baud ticks
  output logic             timer_irq,
  output tmr2_baud_type    baud_tick,
  output logic             tx_baud_select,
  output logic             rx_baud_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]    ctrl_r;
  logic [1:0]    mode_r;
  logic [15:0]   cnt_r;
  logic [15:0]   rld_r;
  logic          rd_done_r;
  logic [2:0]    mcyc_r;
  logic [3:0]    baud_div_r;
  logic          clk_out_r;
  tmr2_pins_type pin_s1_r;
  tmr2_pins_type pin_s2_r;
  logic          trig_prev_r;
  logic          cpin_prev_r;
  logic          ext_edge_r;

  logic          overflow_flag;
  logic          external_trigger_flag;
  logic          external_trigger_enable;
  logic          run_bit;
  logic          timer_counter_select;
  logic          capture_reload_select;
  logic          clock_output_enable;
  logic          down_count_enable;
  tmr2_mode_type mode;

  assign overflow_flag           = ctrl_r[`TMR2_CTRL_OVF];
  assign external_trigger_flag   = ctrl_r[`TMR2_CTRL_EXT];
  assign rx_baud_select          = ctrl_r[`TMR2_CTRL_RXB];
  assign tx_baud_select          = ctrl_r[`TMR2_CTRL_TXB];
  assign external_trigger_enable = ctrl_r[`TMR2_CTRL_EXEN];
  assign run_bit                 = ctrl_r[`TMR2_CTRL_RUN];
  assign timer_counter_select    = ctrl_r[`TMR2_CTRL_CT];
  assign capture_reload_select   = ctrl_r[`TMR2_CTRL_CPRL];
  assign clock_output_enable     = mode_r[`TMR2_MODE_OE];
  assign down_count_enable       = mode_r[`TMR2_MODE_DOWN_COUNT_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb
  begin
    if (!run_bit)
      mode = TMR2_OFF;
    else if (tx_baud_select || rx_baud_select)
      mode = TMR2_BAUD;
    else if (clock_output_enable)
      mode = TMR2_CLKOUT;
    else if (capture_reload_select)
      mode = TMR2_CAPTURE;
    else
      mode = TMR2_RELOAD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= '{count_pin: count_pin_in, trigger_pin: trigger_pin_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle enable: one pulse every six oscillator clocks
  logic mcyc_en;
  assign mcyc_en = (mcyc_r == `TMR2_MCYC_LAST);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mcyc_r <= 3'h0;
    else if (mcyc_en)
      mcyc_r <= 3'h0;
    else
      mcyc_r <= mcyc_r + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edge: high sample, low sample, flag in next machine cycle
  logic trig_fall;
  assign trig_fall = mcyc_en && trig_prev_r && !pin_s2_r.trigger_pin;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trig_prev_r <= 1'b0;
      ext_edge_r  <= 1'b0;
    end
    else if (mcyc_en)
    begin
      trig_prev_r <= pin_s2_r.trigger_pin;
      ext_edge_r  <= trig_fall && external_trigger_enable;
    end
    else
      ext_edge_r  <= 1'b0;
  end

  // Edge acts only in capture, reload (up-only) and baud modes
  logic ext_evt;
  assign ext_evt = ext_edge_r && (mode == TMR2_CAPTURE || mode == TMR2_BAUD ||
                                  (mode == TMR2_RELOAD && !down_count_enable));

  ////////////////////////////////////////////////////////////////////////////
  // Count tick source
  logic cpin_fall;
  logic tick;
  assign cpin_fall = cpin_prev_r && !pin_s2_r.count_pin;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cpin_prev_r <= 1'b0;
    else
      cpin_prev_r <= pin_s2_r.count_pin;
  end

  always_comb
  begin
    if (mode == TMR2_OFF)
      tick = 1'b0;
    else if (timer_counter_select && mode != TMR2_CLKOUT)
      tick = cpin_fall;
    else if (mode == TMR2_BAUD || mode == TMR2_CLKOUT)
      tick = 1'b1;                                        // oscillator rate
    else
      tick = mcyc_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting, rollover and underflow
  logic count_down;
  logic rollover;
  logic underflow;
  assign count_down = (mode == TMR2_RELOAD) && down_count_enable && !pin_s2_r.trigger_pin;
  assign rollover   = tick && !count_down && (cnt_r == `TMR2_ALL_ONES);
  assign underflow  = tick && count_down && (cnt_r == rld_r);

  // Bus write decode
  logic wr_acc;
  assign wr_acc = avs_write && avs_byteenable[0];

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= `TMR2_CNT_RST;
    else if (wr_acc && avs_address == `TMR2_ADDR_CNT_LO)
      cnt_r[7:0] <= avs_writedata[7:0];
    else if (wr_acc && avs_address == `TMR2_ADDR_CNT_HI)
      cnt_r[15:8] <= avs_writedata[7:0];
    else if (underflow)
      cnt_r <= `TMR2_ALL_ONES;
    else if (rollover && mode != TMR2_CAPTURE)
      cnt_r <= rld_r;
    else if (ext_evt && mode == TMR2_RELOAD)
      cnt_r <= rld_r;
    else if (tick && count_down)
      cnt_r <= cnt_r - 16'h0001;
    else if (tick)
      cnt_r <= cnt_r + 16'h0001;                          // capture and baud edges leave it
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reload / capture registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rld_r <= `TMR2_CNT_RST;
    else if (ext_evt && mode == TMR2_CAPTURE)
      rld_r <= cnt_r;
    else if (wr_acc && avs_address == `TMR2_ADDR_RLD_LO)
      rld_r[7:0] <= avs_writedata[7:0];
    else if (wr_acc && avs_address == `TMR2_ADDR_RLD_HI)
      rld_r[15:8] <= avs_writedata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register with hardware flags; hardware set wins over software clear
  logic ovf_set;
  logic ext_set;
  logic ext_tgl;
  logic updown;
  assign updown  = (mode == TMR2_RELOAD) && down_count_enable;
  assign ovf_set = (rollover || underflow) && (mode == TMR2_CAPTURE || mode == TMR2_RELOAD);
  assign ext_tgl = updown && (rollover || underflow);
  assign ext_set = ext_evt;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_r <= `TMR2_CTRL_RST;
    else
    begin
      if (wr_acc && avs_address == `TMR2_ADDR_CTRL)
        ctrl_r <= avs_writedata[7:0];
      if (ovf_set)
        ctrl_r[`TMR2_CTRL_OVF] <= 1'b1;
      if (ext_set)
        ctrl_r[`TMR2_CTRL_EXT] <= 1'b1;
      else if (ext_tgl)
        ctrl_r[`TMR2_CTRL_EXT] <= ~external_trigger_flag;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_r <= `TMR2_MODE_RST;
    else if (wr_acc && avs_address == `TMR2_ADDR_MODE)
      mode_r <= avs_writedata[1:0];
  end

  // Shared interrupt request from both flags
  assign timer_irq = overflow_flag || external_trigger_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Clock-out pin toggles on each rollover
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      clk_out_r <= 1'b0;
    else if (mode == TMR2_CLKOUT && rollover)
      clk_out_r <= ~clk_out_r;
  end

  assign count_pin_out = clk_out_r;
  assign count_pin_oe  = clock_output_enable && !timer_counter_select;

  ////////////////////////////////////////////////////////////////////////////
  // Baud divide by 16 of rollovers
  logic baud_pulse;
  assign baud_pulse = (mode == TMR2_BAUD) && rollover && (baud_div_r == `TMR2_BAUD_DIV_LAST);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      baud_div_r <= 4'h0;
    else if (mode == TMR2_BAUD && rollover)
      baud_div_r <= baud_div_r + 4'h1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      baud_tick <= '0;
    else
    begin
      baud_tick.tx_tick <= baud_pulse && tx_baud_select;
      baud_tick.rx_tick <= baud_pulse && rx_baud_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon read: one wait state, data registered
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_done_r    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      rd_done_r <= avs_read && !rd_done_r;
      case (avs_address)
        `TMR2_ADDR_CTRL:   avs_readdata <= {24'h00_0000, ctrl_r};
        `TMR2_ADDR_MODE:   avs_readdata <= {30'h0000_0000, mode_r};
        `TMR2_ADDR_CNT_LO: avs_readdata <= {24'h00_0000, cnt_r[7:0]};
        `TMR2_ADDR_CNT_HI: avs_readdata <= {24'h00_0000, cnt_r[15:8]};
        `TMR2_ADDR_RLD_LO: avs_readdata <= {24'h00_0000, rld_r[7:0]};
        `TMR2_ADDR_RLD_HI: avs_readdata <= {24'h00_0000, rld_r[15:8]};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest = avs_read && !rd_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_run_gates_count: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!run_bit && !$past(wr_acc)) |=> $stable(cnt_r) || $past(wr_acc))
    else $error("count moved while stopped");

  a_capture_copies: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ext_evt && mode == TMR2_CAPTURE) |=> rld_r == $past(cnt_r))
    else $error("capture did not copy count");

  a_no_ovf_baud: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode == TMR2_BAUD && rollover && !overflow_flag && !wr_acc) |=> !overflow_flag)
    else $error("baud rollover set overflow flag");

  a_up_reload: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode == TMR2_RELOAD && rollover && !wr_acc) |=> cnt_r == $past(rld_r) && overflow_flag)
    else $error("overflow did not reload");

  a_down_underflow: assert property (@(posedge core_clk) disable iff (!arst_n)
    (underflow && !wr_acc) |=> cnt_r == `TMR2_ALL_ONES && overflow_flag)
    else $error("underflow did not load all ones");

  a_ext_toggle: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ext_tgl && !ext_set && !wr_acc) |=> external_trigger_flag != $past(external_trigger_flag))
    else $error("external flag did not toggle");

  a_capture_keeps: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode == TMR2_CAPTURE && rollover && !wr_acc) |=> cnt_r == 16'h0000)
    else $error("capture mode reloaded count");

  a_clkout_toggle: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode == TMR2_CLKOUT && rollover) |=> count_pin_out != $past(count_pin_out) &&
      (!$rose(overflow_flag) || $past(wr_acc)))
    else $error("clock out did not toggle");

endmodule
`default_nettype wire

//--- tb/tmr2_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module tmr2_pin_model
  import tmr2_pkg::*;
(
  // Clock and level commanded by the bench
  input  wire logic           core_clk,
  input  wire logic           trig_level,
  input  wire logic           cnt_level,
  // Design side of the count pin and baud ticks
  input  wire logic           count_pin_out,
  input  wire logic           count_pin_oe,
  input  wire tmr2_baud_type  baud_tick,
  // Pins toward the design
  output tmr2_pins_type       pins,
  // Observed activity
  output int                  tog_cnt,
  output int                  rx_cnt,
  output int                  tx_cnt
);
  logic trig_r;
  logic cnt_r;
  logic last_r;

  ////////////////////////////////////////////////////////////////////////
  // Trigger and external count source change just after an edge; idle count level is high
  always @(posedge core_clk)
  begin
    trig_r <= trig_level;
    cnt_r  <= cnt_level;
  end
  assign pins = '{count_pin: (count_pin_oe ? count_pin_out : cnt_r), trigger_pin: trig_r};

  ////////////////////////////////////////////////////////////////////////
  // Count clock-out toggles and baud ticks as the far side sees them
  always @(posedge core_clk)
  begin
    if (count_pin_oe === 1'b1 && count_pin_out !== last_r)
      tog_cnt++;
    last_r <= count_pin_out;
    if (baud_tick.tx_tick === 1'b1)
      tx_cnt++;
    if (baud_tick.rx_tick === 1'b1)
      rx_cnt++;
  end
endmodule

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_map.svh"

module tb_top
  import tmr2_pkg::*;
;
  localparam logic [2:0] a_ctl = `TMR2_ADDR_CTRL;
  localparam logic [2:0] a_mod = `TMR2_ADDR_MODE;
  localparam logic [2:0] a_cnt = `TMR2_ADDR_CNT_LO;
  localparam logic [2:0] a_rld = `TMR2_ADDR_RLD_LO;
  logic          core_clk, arst_n, avs_read, avs_write, trig_level, cnt_level;
  logic [2:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata, rd;
  logic [3:0]    avs_byteenable;
  logic          avs_waitrequest, count_pin_out, count_pin_oe, timer_irq, tx_sel, rx_sel;
  logic [15:0]   v1, v2;
  tmr2_baud_type baud_tick;
  tmr2_pins_type pins;
  int            tog_cnt, tx_cnt, rx_cnt, errors, check_count, cycles, n0, n2;

  ////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  tmr2_core tmr2_core_i (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_pin_in(pins.count_pin), .count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe),
    .trigger_pin_in(pins.trigger_pin), .timer_irq(timer_irq), .baud_tick(baud_tick),
    .tx_baud_select(tx_sel), .rx_baud_select(rx_sel));
  tmr2_pin_model tmr2_pin_model_i (.core_clk(core_clk), .trig_level(trig_level), .cnt_level(cnt_level),
    .count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe), .baud_tick(baud_tick),
    .pins(pins), .tog_cnt(tog_cnt), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, (got >= lo && got <= hi)}, 32'h1);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Called just after a rising edge; request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task w16(input logic [2:0] a, input logic [15:0] v);
    bus(1'b1, a, v[7:0]);
    bus(1'b1, a + 3'h1, v[15:8]);
  endtask
  task r16(input logic [2:0] a, output logic [15:0] v);
    bus(1'b0, a, 8'h00);
    v[7:0] = rd[7:0];
    bus(1'b0, a + 3'h1, 8'h00);
    v[15:8] = rd[7:0];
  endtask
  // Baud run: rollover every 2 clocks, a tick every 32 clocks on the selected side
  task baud(input logic [7:0] c);
    bus(1'b1, a_ctl, 8'h00);
    w16(a_rld, 16'hfffe);
    w16(a_cnt, 16'hfffe);
    bus(1'b1, a_ctl, c);
    cyc(10);
    n0 = tx_cnt;
    n2 = rx_cnt;
    cyc(320);
    rng(tx_cnt - n0, c[4] ? 9 : 0, c[4] ? 11 : 0);
    rng(rx_cnt - n2, c[5] ? 9 : 0, c[5] ? 11 : 0);
    chk({tx_sel, rx_sel}, {c[4], c[5]});
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, c);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'h1;
    trig_level = 1'b1;
    cnt_level = 1'b1;
    {errors, check_count, cycles} = '0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    // Reset values, unmapped place, stopped timer
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h00);
    bus(1'b0, a_mod, 8'h00);
    chk(rd, 8'h00);
    bus(1'b1, 3'h6, 8'hff);
    bus(1'b0, 3'h6, 8'h00);
    chk(rd, 8'h00);
    w16(a_cnt, 16'h1234);
    cyc(30);
    r16(a_cnt, v1);
    chk(v1, 16'h1234);
    // Count up, overflow reloads
    w16(a_rld, 16'hfff0);
    w16(a_cnt, 16'hfffe);
    bus(1'b1, a_ctl, 8'h04);
    cyc(60);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h84);
    chk(timer_irq, 1'b1);
    bus(1'b1, a_ctl, 8'h80);
    r16(a_cnt, v1);
    rng(v1, 16'hfff0, 16'hfffd);
    cyc(20);
    r16(a_cnt, v2);
    chk(v2, v1);
    // Capture mode without external enable: overflow flags, count wraps to zero
    w16(a_cnt, 16'hfffe);
    bus(1'b1, a_ctl, 8'h05);
    cyc(30);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h85);
    bus(1'b1, a_ctl, 8'h00);
    r16(a_cnt, v1);
    rng(v1, 16'h0000, 16'h0008);
    // Counter select: falling edges on the count pin are counted
    w16(a_cnt, 16'h0000);
    bus(1'b1, a_ctl, 8'h06);
    repeat (4)
    begin
      cnt_level <= 1'b0;
      cyc(4);
      cnt_level <= 1'b1;
      cyc(4);
    end
    cyc(4);
    bus(1'b1, a_ctl, 8'h00);
    r16(a_cnt, v1);
    chk(v1, 16'h0004);
    // Capture twice, count runs on
    bus(1'b1, a_ctl, 8'h00);
    w16(a_cnt, 16'h1000);
    w16(a_rld, 16'habcd);
    bus(1'b1, a_ctl, 8'h0d);
    cyc(30);
    trig_level <= 1'b0;
    cyc(40);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h4d);
    chk(timer_irq, 1'b1);
    r16(a_rld, v1);
    rng(v1, 16'h1000, 16'h1020);
    trig_level <= 1'b1;
    cyc(30);
    trig_level <= 1'b0;
    cyc(40);
    r16(a_rld, v2);
    rng(v2, v1 + 16'h1, v1 + 16'h20);
    bus(1'b1, a_ctl, 8'h00);
    r16(a_cnt, v1);
    rng(v1, v2 + 16'h1, v2 + 16'h20);
    // Trigger edge reloads when counting up
    trig_level <= 1'b1;
    w16(a_cnt, 16'h2000);
    w16(a_rld, 16'h5555);
    bus(1'b1, a_ctl, 8'h0c);
    cyc(30);
    trig_level <= 1'b0;
    cyc(40);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h4c);
    bus(1'b1, a_ctl, 8'h00);
    r16(a_cnt, v1);
    rng(v1, 16'h5555, 16'h5565);
    // Down then up, flag toggling as a 17th bit
    bus(1'b1, a_mod, 8'h01);
    w16(a_cnt, 16'h0102);
    w16(a_rld, 16'h0100);
    bus(1'b1, a_ctl, 8'h04);
    cyc(30);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'hc4);
    trig_level <= 1'b1;
    cyc(150);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h84);
    bus(1'b1, a_ctl, 8'h00);
    r16(a_cnt, v1);
    rng(v1, 16'h0100, 16'h0130);
    // Clock-out: rollover every 4 clocks gives a toggle each time
    bus(1'b1, a_mod, 8'h00);
    w16(a_rld, 16'hfffc);
    w16(a_cnt, 16'hfffc);
    bus(1'b1, a_mod, 8'h02);
    bus(1'b1, a_ctl, 8'h04);
    cyc(10);
    n0 = tog_cnt;
    cyc(80);
    rng(tog_cnt - n0, 19, 21);
    chk(count_pin_oe, 1'b1);
    chk(timer_irq, 1'b0);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h04);
    bus(1'b1, a_mod, 8'h00);
    // Baud sources, each side alone and both
    baud(8'h15);
    baud(8'h24);
    baud(8'h34);
    // Trigger edge in baud mode only flags
    bus(1'b1, a_ctl, 8'h1c);
    trig_level <= 1'b0;
    cyc(40);
    bus(1'b0, a_ctl, 8'h00);
    chk(rd, 8'h5c);
    end_of_test();
  end
endmodule

`default_nettype wire
